// *** design/fpms_pkg.sv ***
`default_nettype none
// Shared constants and types for the flash programming-mode link.
package fpms_pkg;
   // Flash array size in bytes and the matching index width.
   localparam int unsigned FLASH_BYTES = 8192;
   localparam int unsigned FLASH_AW    = 13;
   // Security register sits at the top byte of the mode's address space.
   localparam logic [15:0] SEC_ADDR    = 16'hFFFF;
   localparam logic [15:0] FLASH_LAST  = 16'h1FFF;
   // Security bit positions; a zero means the feature is active.
   localparam int unsigned LOCK_BIT    = 0;
   localparam int unsigned CRR_BIT     = 1;
   localparam int unsigned ENC_BIT     = 2;
   localparam int unsigned OSC_BIT     = 7;
   // Erased value of every cell and of the security register.
   localparam logic [7:0]  ERASED_BYTE = 8'hFF;
   // Value shown instead of real contents when reading is denied.
   localparam logic [7:0]  DENIED_BYTE = 8'h00;
   // Fixed key of the reversible output transform.
   localparam logic [7:0]  ENC_KEY     = 8'hA5;
   // Programmer pin hold and recovery time in clock cycles.
   localparam logic [13:0] OP_CYCLES   = 14'h000C;
   // Programmer register offsets on APB.
   localparam logic [11:0] REG_CTRL    = 12'h000;
   localparam logic [11:0] REG_ADDR    = 12'h004;
   localparam logic [11:0] REG_WDATA   = 12'h008;
   localparam logic [11:0] REG_RDATA   = 12'h00C;
   localparam logic [11:0] REG_STATUS  = 12'h010;
   // Control register fields.
   localparam int unsigned CTRL_OP_LSB = 0;
   localparam int unsigned CTRL_MODE   = 4;

   // Voltage level seen on the supply pin, as a logic code.
   typedef enum logic [1:0] {
      VPP_LOW, VPP_VIH, PROGRAM_LEVEL, ERASE_LEVEL
   } fpms_vpp_t;

   // Decoded operation; the programmer uses the same codes as commands.
   typedef enum logic [2:0] {
      OP_NONE, OP_READ, OP_OUTDIS, OP_PROG, OP_PVERIFY, OP_ERASE, OP_EVERIFY, OP_INHIBIT
   } fpms_op_t;

   // Reversible transform: swap nibbles, then mix with the key.
   function automatic logic [7:0] fpms_encode(input logic [7:0] d);
      fpms_encode = {d[3:0], d[7:4]} ^ ENC_KEY;
   endfunction
endpackage
`default_nettype wire

// *** design/fpms_if.sv ***
`default_nettype none
// Pins between the programmer and the device in programming mode.
interface fpms_if;
   logic                reset_pin;        // High selects programming mode.
   logic                ale;              // Held low in programming mode.
   logic                fetch_strobe_n;   // Held high in programming mode.
   logic                erase_select_ctl; // High selects erase operations.
   logic                aux_ctl_hi;       // Must be low.
   logic                aux_ctl_top;      // Must be low.
   logic                aux_output_ctl;   // Must be low.
   logic                ce_n;             // Chip select, active low.
   logic                oe_n;             // Output gate, active low.
   fpms_pkg::fpms_vpp_t ext_access_n;     // Supply pin level.
   logic [15:0]         addr;             // Byte address, high and low port.
   logic [7:0]          prog_data_o;      // Programmer data drive.
   logic                prog_data_oe;     // Programmer drives the bus.
   logic [7:0]          dev_data_o;       // Device data drive.
   logic                dev_data_oe;      // Device drives the bus.
   logic [7:0]          data_bus;         // Resolved bus level.

   // The bus floats high when nobody drives it; the programmer wins a clash.
   assign data_bus = prog_data_oe ? prog_data_o : (dev_data_oe ? dev_data_o : 8'hFF);

   modport dev (input reset_pin, ale, fetch_strobe_n, erase_select_ctl, aux_ctl_hi,
                aux_ctl_top, aux_output_ctl, ce_n, oe_n, ext_access_n, addr, data_bus,
                output dev_data_o, dev_data_oe);
   modport prog (output reset_pin, ale, fetch_strobe_n, erase_select_ctl, aux_ctl_hi,
                 aux_ctl_top, aux_output_ctl, ce_n, oe_n, ext_access_n, addr,
                 prog_data_o, prog_data_oe, input data_bus);
endinterface
`default_nettype wire

// *** design/fpms_device.sv ***
// Notes on behaviour
// - Reset high, ALE low, strobe high enable.
// - Sixteen-bit address, eight-bit bidirectional data.
// - Read drives stored byte onto bus.
// - Locked part returns no valid read data.
// - Output gate high keeps bus released.
// - Program writes bus byte to location.
// - Program verify outputs the addressed byte.
// - Erase sets all cells and bits one.
// - Programming only clears bits; erase sets.
// - Erase verify outputs the addressed byte.
// - Both selects high inhibit program, erase.
// - Security register at top byte address.
// - Security register hidden in normal mode.
// - Programmed security bits stay low until erase or presetn.
// - Lock denies flash and security access.
// - Code-read restriction limits external code reads.
// - Encryption encodes data driven on bus.
// - Bit seven low halves oscillator gain.
`default_nettype none
module fpms_device (
   // Clock and reset.
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Programming pins.
   fpms_if.dev              link,
   // Normal-mode code read port of the core.
   input  wire logic [15:0] core_addr,
   input  wire logic        core_from_ext,
   output logic [7:0]       core_rdata,
   output logic             core_rdata_ok,
   // Security-derived controls and status.
   output logic             osc_half_gain,
   output logic             code_read_restrict,
   output logic             erase_busy
);
   // Width of the bundle of pins that crosses into the clock domain.
   localparam int unsigned PIN_W = 35;

   // Flash array; it has no reset because its contents are nonvolatile.
   logic [7:0]        mem [fpms_pkg::FLASH_BYTES];
   // Two-stage pin synchronizer; only the second stage is read.
   logic [PIN_W-1:0]  sync1_q;
   logic [PIN_W-1:0]  sync2_q;
   // Pin fields taken from the second synchronizer stage.
   logic              p_rst, p_ale, p_fetch_n, p_esel, p_aux;
   logic              p_ce_n, p_oe_n;
   fpms_pkg::fpms_vpp_t p_vpp;
   logic [15:0]       p_addr;
   logic [7:0]        p_data;
   // Decoded operation and its value one cycle earlier.
   fpms_pkg::fpms_op_t op;
   fpms_pkg::fpms_op_t op_q, op_d;
   // Security register, erase walk and output state.
   logic [7:0]        sec_q, sec_d;
   logic              busy_q, busy_d;
   logic [fpms_pkg::FLASH_AW-1:0] ecnt_q, ecnt_d;
   logic [7:0]        dout_q, dout_d;
   logic              doe_q, doe_d;
   logic [7:0]        crd_q, crd_d;
   logic              cok_q, cok_d;
   logic              osc_q, osc_d;
   logic              crr_q, crr_d;
   // Array write port computed by the next-state logic.
   logic              mem_we;
   logic [fpms_pkg::FLASH_AW-1:0] mem_waddr;
   logic [7:0]        mem_wdata;
   // Helper terms.
   logic              mode;
   logic              unlocked;
   logic              in_flash;
   logic [7:0]        rd_byte;
   logic              core_in_flash;

   // Every pin is an outside input, so all of them pass two flip-flops.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= {link.reset_pin, link.ale, link.fetch_strobe_n, link.erase_select_ctl,
                     link.aux_ctl_hi | link.aux_ctl_top | link.aux_output_ctl,
                     link.ce_n, link.oe_n, link.ext_access_n, link.addr, link.data_bus,
                     2'b00};
         sync2_q <= sync1_q;
      end
   end

   // Unpack the synchronized pins.
   assign {p_rst, p_ale, p_fetch_n, p_esel, p_aux, p_ce_n, p_oe_n} = sync2_q[34:28];
   assign p_vpp  = fpms_pkg::fpms_vpp_t'(sync2_q[27:26]);
   assign p_addr = sync2_q[25:10];
   assign p_data = sync2_q[9:2];

   assign mode     = p_rst & ~p_ale & p_fetch_n;
   assign unlocked = sec_q[fpms_pkg::LOCK_BIT];
   assign in_flash = (p_addr <= fpms_pkg::FLASH_LAST);
   assign core_in_flash = (core_addr <= fpms_pkg::FLASH_LAST);

   // Decode the operation from the pin pattern.
   always_comb begin
      op = fpms_pkg::OP_NONE;
      if (mode && !p_aux) begin
         if (p_ce_n && p_oe_n) begin
            op = fpms_pkg::OP_INHIBIT;
         end else if (!p_esel) begin
            if (!p_ce_n && !p_oe_n && p_vpp == fpms_pkg::VPP_VIH) begin
               op = fpms_pkg::OP_READ;
            end else if (!p_ce_n && p_oe_n && p_vpp == fpms_pkg::VPP_VIH) begin
               op = fpms_pkg::OP_OUTDIS;
            end else if (!p_ce_n && p_oe_n && p_vpp == fpms_pkg::PROGRAM_LEVEL) begin
               op = fpms_pkg::OP_PROG;
            end else if (p_ce_n && !p_oe_n && p_vpp == fpms_pkg::PROGRAM_LEVEL) begin
               op = fpms_pkg::OP_PVERIFY;
            end
         end else begin
            if (!p_ce_n && p_oe_n && p_vpp == fpms_pkg::ERASE_LEVEL && !p_addr[0] &&
                p_data == fpms_pkg::ERASED_BYTE) begin
               op = fpms_pkg::OP_ERASE;
            end else if (p_ce_n && !p_oe_n && p_vpp == fpms_pkg::ERASE_LEVEL) begin
               op = fpms_pkg::OP_EVERIFY;
            end
         end
      end
   end

   // Byte that a read at the synchronized address would show.
   always_comb begin
      if (p_addr == fpms_pkg::SEC_ADDR) begin
         rd_byte = sec_q;
      end else if (in_flash) begin
         rd_byte = mem[p_addr[fpms_pkg::FLASH_AW-1:0]];
      end else begin
         rd_byte = fpms_pkg::ERASED_BYTE;
      end
      if (!unlocked || busy_q) begin
         rd_byte = fpms_pkg::DENIED_BYTE;
      end
   end

   // Next state of the security register, array and data outputs.
   always_comb begin
      op_d      = op;
      sec_d     = sec_q;
      busy_d    = busy_q;
      ecnt_d    = ecnt_q;
      mem_we    = 1'b0;
      mem_waddr = p_addr[fpms_pkg::FLASH_AW-1:0];
      mem_wdata = fpms_pkg::ERASED_BYTE;
      // A program or erase acts once, on entry into the operation.
      if (busy_q) begin
         // The erase walk rewrites one byte per cycle; only presetn can stop it.
         mem_we    = 1'b1;
         mem_waddr = ecnt_q;
         ecnt_d    = ecnt_q + 1'b1;
         if (ecnt_q == fpms_pkg::FLASH_LAST[fpms_pkg::FLASH_AW-1:0]) begin
            busy_d = 1'b0;
         end
      end else if (op == fpms_pkg::OP_ERASE && op_q != fpms_pkg::OP_ERASE) begin
         sec_d  = fpms_pkg::ERASED_BYTE;
         busy_d = 1'b1;
         ecnt_d = '0;
      end else if (op == fpms_pkg::OP_PROG && op_q != fpms_pkg::OP_PROG && unlocked) begin
         if (p_addr == fpms_pkg::SEC_ADDR) begin
            sec_d = sec_q & p_data;
         end else if (in_flash) begin
            mem_we    = 1'b1;
            mem_wdata = rd_byte & p_data;
         end
      end
      doe_d = (op == fpms_pkg::OP_READ) || (op == fpms_pkg::OP_PVERIFY) ||
              (op == fpms_pkg::OP_EVERIFY);
      // encode when enabled
      // A denied read shows the plain filler byte, so no key material leaks out.
      if (!sec_q[fpms_pkg::ENC_BIT] && unlocked && !busy_q) begin
         dout_d = fpms_pkg::fpms_encode(rd_byte);
      end else begin
         dout_d = rd_byte;
      end
      cok_d = !mode && core_in_flash &&
              (!core_from_ext || sec_q[fpms_pkg::CRR_BIT]);
      crd_d = cok_d ? mem[core_addr[fpms_pkg::FLASH_AW-1:0]] : fpms_pkg::DENIED_BYTE;
      osc_d  = ~sec_q[fpms_pkg::OSC_BIT];
      crr_d  = ~sec_q[fpms_pkg::CRR_BIT];
   end

   // Control and output registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_q   <= fpms_pkg::OP_NONE;
         sec_q  <= fpms_pkg::ERASED_BYTE;
         busy_q <= 1'b0;
         ecnt_q <= '0;
         dout_q <= 8'h00;
         doe_q  <= 1'b0;
         crd_q  <= 8'h00;
         cok_q  <= 1'b0;
         osc_q  <= 1'b0;
         crr_q  <= 1'b0;
      end else begin
         op_q   <= op_d;
         sec_q  <= sec_d;
         busy_q <= busy_d;
         ecnt_q <= ecnt_d;
         dout_q <= dout_d;
         doe_q  <= doe_d;
         crd_q  <= crd_d;
         cok_q  <= cok_d;
         osc_q  <= osc_d;
         crr_q  <= crr_d;
      end
   end

   // Array write port; the array itself holds its data across reset.
   always_ff @(posedge pclk) begin
      if (mem_we) begin
         mem[mem_waddr] <= mem_wdata;
      end
   end

   assign link.dev_data_o  = dout_q;
   assign link.dev_data_oe = doe_q;
   assign core_rdata         = crd_q;
   assign core_rdata_ok      = cok_q;
   assign osc_half_gain      = osc_q;
   assign code_read_restrict = crr_q;
   assign erase_busy         = busy_q;
endmodule
`default_nettype wire

// *** design/fpms_programmer.sv ***
`default_nettype none
// Programmer end: software orders pin operations over APB.
module fpms_programmer #(
   // Hold time of the erase pattern; the device walks the whole array.
   parameter logic [13:0] ERASE_CYCLES = 14'h2008
) (
   // Clock and reset.
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Programming pins.
   fpms_if.prog             link
);
   // Sequencer states.
   typedef enum logic [1:0] {ST_IDLE, ST_DRIVE, ST_RELEASE} fpms_st_t;

   fpms_st_t          st_q, st_d;
   fpms_pkg::fpms_op_t cmd_q, cmd_d;     // Operation being driven.
   logic              mode_q, mode_d;    // Holds the device in programming mode.
   logic [15:0]       addr_q, addr_d;    // Address register.
   logic [7:0]        wdat_q, wdat_d;    // Write data register.
   logic [7:0]        rdat_q, rdat_d;    // Last sampled bus byte.
   logic [13:0]       cnt_q, cnt_d;      // Hold counter.
   logic [7:0]        sync1_q, sync2_q;  // Bus synchronizer.
   // Pin registers.
   logic              ce_q, ce_d, oe_q, oe_d, es_q, es_d, doe_q, doe_d;
   fpms_pkg::fpms_vpp_t vpp_q, vpp_d;
   logic [15:0]       pa_q, pa_d;
   logic [7:0]        pd_q, pd_d;
   // APB answer registers.
   logic [31:0]       prd_q, prd_d;
   logic              rdy_q, rdy_d, err_q, err_d;
   logic              access, wr_ctrl;

   // The bus comes from the device pins, so it passes two flip-flops.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= 8'h00;
         sync2_q <= 8'h00;
      end else begin
         sync1_q <= link.data_bus;
         sync2_q <= sync1_q;
      end
   end

   // A write or read takes effect on the edge where pready is seen high.
   assign access  = psel & penable & rdy_q;
   assign wr_ctrl = access & pwrite & (paddr == fpms_pkg::REG_CTRL);

   // Register file, APB answer and pin sequencer.
   always_comb begin
      st_d = st_q; cmd_d = cmd_q; mode_d = mode_q; addr_d = addr_q; wdat_d = wdat_q;
      rdat_d = rdat_q; cnt_d = cnt_q;
      ce_d = 1'b1; oe_d = 1'b1; es_d = 1'b0; doe_d = 1'b0; vpp_d = fpms_pkg::VPP_VIH;
      pa_d = addr_q; pd_d = wdat_q;
      // One wait state: pready rises in the second access cycle.
      rdy_d = psel & penable & ~rdy_q;
      prd_d = 32'h0000_0000;
      err_d = 1'b0;
      unique case (paddr)
         fpms_pkg::REG_CTRL:   prd_d = {27'h0, mode_q, 1'b0, cmd_q};
         fpms_pkg::REG_ADDR:   prd_d = {16'h0, addr_q};
         fpms_pkg::REG_WDATA:  prd_d = {24'h0, wdat_q};
         fpms_pkg::REG_RDATA:  prd_d = {24'h0, rdat_q};
         fpms_pkg::REG_STATUS: prd_d = {31'h0, st_q != ST_IDLE};
         default:              err_d = 1'b1;
      endcase
      if (access && pwrite && st_q == ST_IDLE) begin
         if (paddr == fpms_pkg::REG_ADDR) addr_d = pwdata[15:0];
         if (paddr == fpms_pkg::REG_WDATA) wdat_d = pwdata[7:0];
      end
      unique case (st_q)
         ST_IDLE: begin
            // Orders arriving while busy are ignored.
            if (wr_ctrl) begin
               mode_d = pwdata[fpms_pkg::CTRL_MODE];
               cmd_d  = fpms_pkg::fpms_op_t'(pwdata[fpms_pkg::CTRL_OP_LSB +: 3]);
               if (cmd_d != fpms_pkg::OP_NONE && mode_d) begin
                  st_d  = ST_DRIVE;
                  cnt_d = (cmd_d == fpms_pkg::OP_ERASE) ? ERASE_CYCLES : fpms_pkg::OP_CYCLES;
               end
            end
         end
         ST_DRIVE: begin
            unique case (cmd_q)
               fpms_pkg::OP_READ:    begin ce_d = 1'b0; oe_d = 1'b0; end
               fpms_pkg::OP_OUTDIS:  begin ce_d = 1'b0; end
               fpms_pkg::OP_PROG:    begin ce_d = 1'b0; doe_d = 1'b1;
                                           vpp_d = fpms_pkg::PROGRAM_LEVEL; end
               fpms_pkg::OP_PVERIFY: begin oe_d = 1'b0; vpp_d = fpms_pkg::PROGRAM_LEVEL; end
               fpms_pkg::OP_ERASE:   begin ce_d = 1'b0; es_d = 1'b1; doe_d = 1'b1;
                                           vpp_d = fpms_pkg::ERASE_LEVEL;
                                           pa_d = {addr_q[15:1], 1'b0};
                                           pd_d = fpms_pkg::ERASED_BYTE; end
               fpms_pkg::OP_EVERIFY: begin oe_d = 1'b0; es_d = 1'b1;
                                           vpp_d = fpms_pkg::ERASE_LEVEL; end
               fpms_pkg::OP_INHIBIT: begin vpp_d = fpms_pkg::PROGRAM_LEVEL; end
               default:              begin end
            endcase
            cnt_d = cnt_q - 1'b1;
            if (cnt_q == 14'h0000) begin
               rdat_d = sync2_q;
               st_d   = ST_RELEASE;
               cnt_d  = fpms_pkg::OP_CYCLES;
            end
         end
         ST_RELEASE: begin
            // Idle pins let the device see the end of the operation.
            cnt_d = cnt_q - 1'b1;
            if (cnt_q == 14'h0000) st_d = ST_IDLE;
         end
         default: st_d = ST_IDLE;
      endcase
   end

   // State registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= ST_IDLE; cmd_q <= fpms_pkg::OP_NONE; mode_q <= 1'b0;
         addr_q <= 16'h0000; wdat_q <= 8'h00; rdat_q <= 8'h00; cnt_q <= 14'h0000;
         ce_q <= 1'b1; oe_q <= 1'b1; es_q <= 1'b0; doe_q <= 1'b0;
         vpp_q <= fpms_pkg::VPP_VIH; pa_q <= 16'h0000; pd_q <= 8'h00;
         prd_q <= 32'h0000_0000; rdy_q <= 1'b0; err_q <= 1'b0;
      end else begin
         st_q <= st_d; cmd_q <= cmd_d; mode_q <= mode_d;
         addr_q <= addr_d; wdat_q <= wdat_d; rdat_q <= rdat_d; cnt_q <= cnt_d;
         ce_q <= ce_d; oe_q <= oe_d; es_q <= es_d; doe_q <= doe_d;
         vpp_q <= vpp_d; pa_q <= pa_d; pd_q <= pd_d;
         prd_q <= prd_d; rdy_q <= rdy_d; err_q <= err_d & rdy_d;
      end
   end

   assign link.reset_pin        = mode_q;
   assign link.ale              = 1'b0;
   assign link.fetch_strobe_n   = 1'b1;
   assign link.aux_ctl_hi       = 1'b0;
   assign link.aux_ctl_top      = 1'b0;
   assign link.aux_output_ctl   = 1'b0;
   assign link.erase_select_ctl = es_q;
   assign link.ce_n             = ce_q;
   assign link.oe_n             = oe_q;
   assign link.ext_access_n     = vpp_q;
   assign link.addr             = pa_q;
   assign link.prog_data_o      = pd_q;
   assign link.prog_data_oe     = doe_q;
   assign prdata  = prd_q;
   assign pready  = rdy_q;
   assign pslverr = err_q;
endmodule
`default_nettype wire

// *** design/fpms_programmer_fix.sv ***
`default_nettype none
`default_nettype wire

// *** dv/fpms_link_sva.sv ***
`default_nettype none
// Watches the pins between programmer and device; both ends are design code.
module fpms_link_sva (
   // Clock and reset.
   input wire logic                pclk,
   input wire logic                presetn,
   // Mode and control pins.
   input wire logic                reset_pin,
   input wire logic                ale,
   input wire logic                fetch_strobe_n,
   input wire logic                erase_select_ctl,
   input wire logic                aux_ctl_hi,
   input wire logic                aux_ctl_top,
   input wire logic                aux_output_ctl,
   input wire logic                ce_n,
   input wire logic                oe_n,
   input wire fpms_pkg::fpms_vpp_t ext_access_n,
   // Address and data drive.
   input wire logic [15:0]         addr,
   input wire logic [7:0]          prog_data_o,
   input wire logic                prog_data_oe,
   input wire logic                dev_data_oe
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Common mode condition; four cycles cover the two-flop sampler and the output flop.
   wire logic base = reset_pin && !ale && fetch_strobe_n && !aux_ctl_hi && !aux_ctl_top
                     && !aux_output_ctl;
   sequence s_read;
      (base && !erase_select_ctl && !ce_n && !oe_n && ext_access_n == fpms_pkg::VPP_VIH)[*4];
   endsequence
   sequence s_pver;
      (base && !erase_select_ctl && ce_n && !oe_n
       && ext_access_n == fpms_pkg::PROGRAM_LEVEL)[*4];
   endsequence
   sequence s_ever;
      (base && erase_select_ctl && ce_n && !oe_n && ext_access_n == fpms_pkg::ERASE_LEVEL)[*4];
   endsequence
   a_gate_quiet: assert property (oe_n[*4] |-> !dev_data_oe) else $error("bus driven, gate high");
   a_read_drive: assert property (s_read |-> dev_data_oe) else $error("read not driven");
   a_pver_drive: assert property (s_pver |-> dev_data_oe) else $error("verify not driven");
   a_ever_drive: assert property (s_ever |-> dev_data_oe) else $error("erase verify idle");
   a_idle_quiet: assert property ((!reset_pin)[*4] |-> !dev_data_oe) else $error("drive outside mode");
   a_mode_pins: assert property (!ce_n |-> base) else $error("mode pins wrong");
   a_prog_pattern: assert property (!ce_n && ext_access_n == fpms_pkg::PROGRAM_LEVEL
      |-> oe_n && prog_data_oe) else $error("program pattern wrong");
   a_erase_pattern: assert property (erase_select_ctl && !ce_n |-> oe_n && !addr[0]
      && ext_access_n == fpms_pkg::ERASE_LEVEL && prog_data_oe && prog_data_o == 8'hFF)
      else $error("erase pattern wrong");
   a_addr_hold: assert property ($fell(ce_n) |=> ($stable(addr) && !ce_n)[*8])
      else $error("address moved");
   a_bus_owner: assert property (!(prog_data_oe && dev_data_oe)) else $error("bus clash");
endmodule
`default_nettype wire

// *** dv/flash_program_mode_security_tb.sv ***
`default_nettype none
module flash_program_mode_security_tb;
   timeunit 1ns;
   timeprecision 1ps;
`define chk(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; $display("BAD %0t got %h want %h", $time, g, e); end end
   // Bench-driven inputs, all valued at time zero.
   logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic        core_from_ext = 1'h0, pready, pslverr, re, core_rdata_ok, osc_half_gain;
   logic        code_read_restrict, erase_busy;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rv, lfsr = 32'h7805;
   logic [15:0] core_addr = 16'h0, a;
   logic [7:0]  core_rdata, rb, sec = 8'hFF;
   logic [7:0]  mem [logic [15:0]];
   int          n_fail = 0, compares = 0, cyc = 0;
   fpms_if link_if ();
   fpms_device fpms_device_inst (.pclk(pclk), .presetn(presetn), .link(link_if),
      .core_addr(core_addr), .core_from_ext(core_from_ext), .core_rdata(core_rdata),
      .core_rdata_ok(core_rdata_ok), .osc_half_gain(osc_half_gain),
      .code_read_restrict(code_read_restrict), .erase_busy(erase_busy));
   fpms_programmer #(.ERASE_CYCLES(14'h2008)) fpms_programmer_inst (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link_if));
   fpms_link_sva fpms_link_sva_inst (.pclk(pclk), .presetn(presetn),
      .reset_pin(link_if.reset_pin), .ale(link_if.ale), .fetch_strobe_n(link_if.fetch_strobe_n),
      .erase_select_ctl(link_if.erase_select_ctl), .aux_ctl_hi(link_if.aux_ctl_hi),
      .aux_ctl_top(link_if.aux_ctl_top), .aux_output_ctl(link_if.aux_output_ctl),
      .ce_n(link_if.ce_n), .oe_n(link_if.oe_n), .ext_access_n(link_if.ext_access_n),
      .addr(link_if.addr), .prog_data_o(link_if.prog_data_o),
      .prog_data_oe(link_if.prog_data_oe), .dev_data_oe(link_if.dev_data_oe));
   // Clock at 40 MHz; a cycle ceiling cuts a hang short.
   always #12.5 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 40000) begin
         n_fail++;
         close_out();
      end
   end
   // Expected read view: lock hides all, encryption scrambles the rest.
   function automatic logic [7:0] view(input logic [15:0] x);
      logic [7:0] d;
      d = (x == 16'hFFFF) ? sec : (mem.exists(x) ? mem[x] : 8'hFF);
      if (!sec[0]) return 8'h00;
      return sec[2] ? d : ({d[3:0], d[7:4]} ^ fpms_pkg::ENC_KEY);
   endfunction
   // One APB transfer; holds the request until pready is sampled high.
   task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= ad; pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rv = prdata; re = pslverr; psel <= 1'h0; penable <= 1'h0;
   endtask
   // Orders one pin operation, waits for idle, and fetches the sampled byte.
   task automatic op(input logic [2:0] o, input logic [15:0] x, input logic [7:0] d);
      apb(1'h1, fpms_pkg::REG_ADDR, {16'h0, x});
      apb(1'h1, fpms_pkg::REG_WDATA, {24'h0, d});
      apb(1'h1, fpms_pkg::REG_CTRL, {27'h0, 1'h1, 1'h0, o});
      do apb(1'h0, fpms_pkg::REG_STATUS, 32'h0); while (rv[0] !== 1'h0);
      apb(1'h0, fpms_pkg::REG_RDATA, 32'h0);
      rb = rv[7:0];
   endtask
   // Program then verify; bits only ever clear, and a lock refuses the write.
   task automatic pg(input logic [15:0] x, input logic [7:0] d);
      op(3'h3, x, d);
      if (sec[0] && x == 16'hFFFF) sec = sec & d;
      else if (sec[0]) mem[x] = (mem.exists(x) ? mem[x] : 8'hFF) & d;
      op(3'h4, x, 8'h00);
      `chk(rb, view(x))
   endtask
   task automatic ers();
      op(3'h5, 16'h0000, 8'hFF);
      mem.delete();
      sec = 8'hFF;
   endtask
   task automatic close_out();
      if (n_fail == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, 12'hFFC, 32'h0);
      `chk(re, 1'h1)
      ers();
      repeat (4) begin
         lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
         op(3'h6, {3'h0, lfsr[12:0]}, 8'h00);
         `chk(rb, 8'hFF)
      end
      op(3'h1, 16'hFFFF, 8'h00);
      `chk(rb, 8'hFF)
      pg(fpms_pkg::FLASH_LAST, 8'h00);
      for (int i = 0; i < 6; i++) begin
         lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
         a = {3'h0, lfsr[12:0]};
         pg(a, lfsr[23:16]);
         pg(a, lfsr[31:24]);
         op(3'h1, a, 8'h00);
         `chk(rb, view(a))
      end
      op(3'h2, a, 8'h00);
      `chk(rb, 8'hFF)
      op(3'h7, a, ~view(a));
      `chk(rb, 8'hFF)
      op(3'h1, a, 8'h00);
      `chk(rb, view(a))
      apb(1'h1, fpms_pkg::REG_CTRL, 32'h0);
      repeat (3) @(posedge pclk);
      core_addr <= a;
      core_from_ext <= 1'h1;
      @(posedge pclk);
      @(negedge pclk);
      `chk(core_rdata, mem[a])
      `chk(core_rdata_ok, 1'h1)
      pg(16'hFFFF, 8'h79);
      `chk(osc_half_gain, 1'h1)
      `chk(code_read_restrict, 1'h1)
      op(3'h1, a, 8'h00);
      `chk(rb, view(a))
      pg(16'hFFFF, 8'hFF);
      pg(16'hFFFF, 8'h78);
      op(3'h1, a, 8'h00);
      `chk(rb, 8'h00)
      ers();
      op(3'h1, 16'hFFFF, 8'h00);
      `chk(rb, 8'hFF)
      op(3'h1, a, 8'h00);
      `chk(rb, 8'hFF)
      `chk(osc_half_gain, 1'h0)
      close_out();
   end
endmodule
`default_nettype wire
